/* File: csld_pkg.sv */
// shared constants and types of the compressed stack load/store decoder
package csld_pkg;
   // instruction field patterns
   localparam logic [3:0] PFX_SPLS = 4'h9;
   localparam logic [3:0] PFX_ADR = 4'ha;
   localparam logic [3:0] PFX_MISC = 4'hb;
   localparam logic [3:0] SUB_ADDSP = 4'h0;
   localparam logic [1:0] SUB_PP = 2'h2;
   // program counter read-ahead and bit 1 clear mask
   localparam logic [31:0] PC_AHEAD = 32'h4;
   localparam logic [31:0] PC_BIT1_CLR = 32'hffff_fffd;
   // stack slot 8 is link register on push, program counter on pop
   localparam logic [3:0] LR_SLOT = 4'h8;
   localparam logic [31:0] WORD_STEP = 32'h4;
   // register byte offsets on the apb
   localparam logic [7:0] OFF_SP = 8'h20;
   localparam logic [7:0] OFF_LR = 8'h24;
   localparam logic [7:0] OFF_PC = 8'h28;
   localparam logic [7:0] OFF_FLAGS = 8'h2c;
   localparam logic [7:0] OFF_CTRL = 8'h30;
   localparam logic [7:0] OFF_STAT = 8'h34;
   // field positions
   localparam int unsigned CTRL_EN_BIT = 0;
   localparam int unsigned STAT_BUSY_BIT = 0;
   localparam int unsigned STAT_ILL_BIT = 1;
   localparam int unsigned STAT_CYC_LSB = 8;
   // values after reset and the cycle count step
   localparam logic [31:0] SP_RST = 32'h0;
   localparam logic EN_RST = 1'b1;
   localparam logic [7:0] CYC_ONE = 8'h1;

   typedef enum logic [2:0]
   {
      OP_NONE = 3'h0,
      OP_SPLS = 3'h1,
      OP_ADR = 3'h2,
      OP_ADDSP = 3'h3,
      OP_PP = 3'h4
   } csld_op_t;

   // gray codes along idle, mem, internal, refill
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_MEM = 2'b01,
      ST_INT = 2'b11,
      ST_REFILL = 2'b10
   } csld_state_t;

   typedef struct packed
   {
      csld_op_t op;
      logic load;
      logic sp_base;
      logic neg;
      logic [2:0] rd;
      logic [9:0] imm;
      logic [8:0] mask;
   } csld_dec_t;

   typedef struct packed
   {
      logic valid;
      logic we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } csld_mreq_t;
endpackage

/* File: csld_decode.sv */
// field decode of one compressed stack instruction
module csld_decode
   import csld_pkg::*;
(
   input wire logic [15:0] word,
   output csld_dec_t dec
);
   always_comb
   begin
      dec = '0;
      dec.rd = word[10:8];
      dec.load = word[11];
      dec.sp_base = word[11];
      dec.imm = {word[7:0], 2'b00};
      dec.mask = word[8:0];
      if (word[15:12] == PFX_SPLS)
      begin
         dec.op = OP_SPLS;
      end
      else if (word[15:12] == PFX_ADR)
      begin
         dec.op = OP_ADR;
      end
      else if (word[15:8] == {PFX_MISC, SUB_ADDSP})
      begin
         dec.op = OP_ADDSP;
         dec.neg = word[7];
         dec.imm = {1'b0, word[6:0], 2'b00};
      end
      else if (word[15:12] == PFX_MISC && word[10:9] == SUB_PP)
      begin
         dec.op = OP_PP;
      end
   end
endmodule // csld_decode

/* File: csld_reglist.sv */
// lowest selected slot and slot count of a stack register mask
module csld_reglist
   import csld_pkg::*;
#(
   parameter int unsigned NSLOT = 9
)
(
   input wire logic [NSLOT-1:0] mask,
   output logic [3:0] first,
   output logic [3:0] count
);
   always_comb
   begin
      first = 4'h0;
      count = 4'h0;
      for (int i = NSLOT - 1; i >= 0; i--)
      begin
         if (mask[i])
         begin
            first = 4'(i);
            count = count + 4'h1;
         end
      end
   end
endmodule // csld_reglist

/* File: csld_core.sv */
// execute unit for stack-relative, address, stack adjust and push/pop instructions
//
// The APB interface to the registers and the placing of the registers were decided locally.
module csld_core
   import csld_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ins_valid,
   output logic ins_ready,
   input wire logic [15:0] ins_word,
   input wire logic [31:0] ins_addr,
   output logic done,
   output logic illegal,
   output logic branch_valid,
   output logic [31:0] branch_target,
   output logic mem_req,
   output logic mem_we,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_ack
);
   csld_state_t state_ff, nxt_state;
   logic [31:0] low_ff [8];
   logic [31:0] nxt_low [8];
   logic [31:0] sp_ff, nxt_sp, lr_ff, nxt_lr, pc_ff, nxt_pc, sp_new_ff, nxt_sp_new;
   logic [3:0] flags_ff, nxt_flags, cur_ff, nxt_cur;
   logic [8:0] rem_ff, nxt_rem;
   logic en_ff, nxt_en, ld_ff, nxt_ld, spwb_ff, nxt_spwb, refill_ff, nxt_refill;
   logic done_ff, nxt_done, br_ff, nxt_br, ill_ff, nxt_ill, lastill_ff, nxt_lastill;
   logic [7:0] cyc_ff, nxt_cyc, last_cyc_ff, nxt_last_cyc;
   logic [31:0] prdata_ff, nxt_prdata;
   logic perr_ff, nxt_perr;
   csld_mreq_t mem_ff, nxt_mem;
   csld_dec_t dec;
   logic [8:0] rl_mask;
   logic [3:0] rl_first, rl_count;
   logic fire, fin;
   logic [31:0] ofs;

   function automatic logic [8:0] onehot(input logic [3:0] idx);
      onehot = 9'h1 << idx;
   endfunction

   function automatic logic [31:0] imm32(input logic [9:0] imm);
      imm32 = {22'h0, imm};
   endfunction

   csld_decode u_decode
   (
      .word(ins_word),
      .dec(dec)
   );

   assign rl_mask = (state_ff == ST_IDLE) ? dec.mask : rem_ff;

   csld_reglist #(.NSLOT(9)) u_reglist
   (
      .mask(rl_mask),
      .first(rl_first),
      .count(rl_count)
   );

   assign ins_ready = (state_ff == ST_IDLE) && en_ff && !psel;
   assign fire = ins_valid && ins_ready;
   assign pready = 1'b1;
   assign prdata = prdata_ff;
   assign pslverr = perr_ff && psel && penable;
   assign done = done_ff;
   assign illegal = ill_ff;
   assign branch_valid = br_ff;
   assign branch_target = pc_ff;
   assign mem_req = mem_ff.valid;
   assign mem_we = mem_ff.we;
   assign mem_addr = mem_ff.addr;
   assign mem_wdata = mem_ff.wdata;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      nxt_state = state_ff;
      nxt_low = low_ff;
      nxt_sp = sp_ff;
      nxt_lr = lr_ff;
      nxt_pc = pc_ff;
      nxt_flags = flags_ff;
      nxt_en = en_ff;
      nxt_cur = cur_ff;
      nxt_rem = rem_ff;
      nxt_ld = ld_ff;
      nxt_spwb = spwb_ff;
      nxt_sp_new = sp_new_ff;
      nxt_refill = refill_ff;
      nxt_mem = mem_ff;
      nxt_done = 1'b0;
      nxt_br = 1'b0;
      nxt_ill = 1'b0;
      nxt_lastill = lastill_ff;
      nxt_cyc = (state_ff == ST_IDLE) ? cyc_ff : cyc_ff + CYC_ONE;
      nxt_last_cyc = last_cyc_ff;
      nxt_prdata = prdata_ff;
      nxt_perr = perr_ff;
      fin = 1'b0;
      ofs = {26'h0, rl_count, 2'b00};
      case (state_ff)
         ST_IDLE:
         begin
            if (fire)
            begin
               nxt_cyc = CYC_ONE;
               nxt_lastill = 1'b0;
               case (dec.op)
                  OP_ADR:
                  begin
                     if (dec.sp_base)
                     begin
                        nxt_low[dec.rd] = sp_ff + imm32(dec.imm);
                     end
                     else
                     begin
                        nxt_low[dec.rd] = ((ins_addr + PC_AHEAD) & PC_BIT1_CLR) + imm32(dec.imm);
                     end
                     fin = 1'b1;
                  end
                  OP_ADDSP:
                  begin
                     nxt_sp = dec.neg ? sp_ff - imm32(dec.imm) : sp_ff + imm32(dec.imm);
                     fin = 1'b1;
                  end
                  OP_SPLS:
                  begin
                     // single word at stack plus offset
                     nxt_cur = {1'b0, dec.rd};
                     nxt_rem = 9'h0;
                     nxt_ld = dec.load;
                     nxt_spwb = 1'b0;
                     nxt_refill = 1'b0;
                     nxt_mem.valid = 1'b1;
                     nxt_mem.we = !dec.load;
                     nxt_mem.addr = sp_ff + imm32(dec.imm);
                     nxt_mem.wdata = low_ff[dec.rd];
                     nxt_state = ST_MEM;
                  end
                  OP_PP:
                  begin
                     if (rl_count == 4'h0)
                     begin
                        fin = 1'b1;
                     end
                     else
                     begin
                        // full descending base and new pointer
                        nxt_cur = rl_first;
                        nxt_rem = dec.mask & ~onehot(rl_first);
                        nxt_ld = dec.load;
                        nxt_spwb = 1'b1;
                        nxt_sp_new = dec.load ? sp_ff + ofs : sp_ff - ofs;
                        nxt_refill = dec.load && dec.mask[8];
                        nxt_mem.valid = 1'b1;
                        nxt_mem.we = !dec.load;
                        nxt_mem.addr = dec.load ? sp_ff : sp_ff - ofs;
                        // slot 8 carries the link register
                        nxt_mem.wdata = (rl_first == LR_SLOT) ? lr_ff : low_ff[rl_first[2:0]];
                        nxt_state = ST_MEM;
                     end
                  end
                  default:
                  begin
                     nxt_ill = 1'b1;
                     nxt_lastill = 1'b1;
                     fin = 1'b1;
                  end
               endcase
            end
         end
         ST_MEM:
         begin
            if (mem_ack)
            begin
               if (ld_ff)
               begin
                  if (cur_ff == LR_SLOT)
                  begin
                     nxt_pc = mem_rdata;
                  end
                  else
                  begin
                     nxt_low[cur_ff[2:0]] = mem_rdata;
                  end
               end
               if (rem_ff != 9'h0)
               begin
                  nxt_cur = rl_first;
                  nxt_rem = rem_ff & ~onehot(rl_first);
                  nxt_mem.addr = mem_ff.addr + WORD_STEP;
                  nxt_mem.wdata = (rl_first == LR_SLOT) ? lr_ff : low_ff[rl_first[2:0]];
               end
               else
               begin
                  nxt_mem.valid = 1'b0;
                  // internal cycle after the last load
                  if (ld_ff)
                  begin
                     nxt_state = ST_INT;
                  end
                  else
                  begin
                     fin = 1'b1;
                  end
               end
            end
         end
         ST_INT:
         begin
            if (refill_ff)
            begin
               nxt_state = ST_REFILL;
            end
            else
            begin
               fin = 1'b1;
            end
         end
         default:
         begin
            // two refill cycles after a return
            if (refill_ff)
            begin
               nxt_refill = 1'b0;
            end
            else
            begin
               nxt_br = 1'b1;
               fin = 1'b1;
            end
         end
      endcase
      if (fin)
      begin
         nxt_state = ST_IDLE;
         nxt_done = 1'b1;
         nxt_last_cyc = cyc_ff + CYC_ONE;
         nxt_cyc = 8'h0;
         nxt_spwb = 1'b0;
         if (spwb_ff)
         begin
            nxt_sp = sp_new_ff;
         end
      end
      // apb setup phase: read data and error prepared
      if (psel && !penable)
      begin
         nxt_prdata = 32'h0;
         nxt_perr = pwrite && (state_ff != ST_IDLE);
         if (paddr[7:5] == 3'h0 && paddr[1:0] == 2'h0)
         begin
            nxt_prdata = low_ff[paddr[4:2]];
         end
         else if (paddr == OFF_SP)
         begin
            nxt_prdata = sp_ff;
         end
         else if (paddr == OFF_LR)
         begin
            nxt_prdata = lr_ff;
         end
         else if (paddr == OFF_PC)
         begin
            nxt_prdata = pc_ff;
         end
         else if (paddr == OFF_FLAGS)
         begin
            nxt_prdata = {28'h0, flags_ff};
         end
         else if (paddr == OFF_CTRL)
         begin
            nxt_prdata[CTRL_EN_BIT] = en_ff;
         end
         else if (paddr == OFF_STAT)
         begin
            nxt_prdata[STAT_BUSY_BIT] = (state_ff != ST_IDLE);
            nxt_prdata[STAT_ILL_BIT] = lastill_ff;
            nxt_prdata[STAT_CYC_LSB +: 8] = last_cyc_ff;
         end
         else
         begin
            nxt_perr = 1'b1;
         end
      end
      // apb access phase: write takes effect
      if (psel && penable && pwrite && !perr_ff)
      begin
         if (paddr[7:5] == 3'h0)
         begin
            nxt_low[paddr[4:2]] = pwdata;
         end
         else if (paddr == OFF_SP)
         begin
            nxt_sp = pwdata;
         end
         else if (paddr == OFF_LR)
         begin
            nxt_lr = pwdata;
         end
         else if (paddr == OFF_PC)
         begin
            nxt_pc = pwdata;
         end
         else if (paddr == OFF_FLAGS)
         begin
            nxt_flags = pwdata[3:0];
         end
         else if (paddr == OFF_CTRL)
         begin
            nxt_en = pwdata[CTRL_EN_BIT];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_ff <= ST_IDLE;
         low_ff <= '{default: 32'h0};
         sp_ff <= SP_RST;
         lr_ff <= 32'h0;
         pc_ff <= 32'h0;
         flags_ff <= 4'h0;
         en_ff <= EN_RST;
         cur_ff <= 4'h0;
         rem_ff <= 9'h0;
         ld_ff <= 1'b0;
         spwb_ff <= 1'b0;
         sp_new_ff <= 32'h0;
         refill_ff <= 1'b0;
         mem_ff <= '0;
         done_ff <= 1'b0;
         br_ff <= 1'b0;
         ill_ff <= 1'b0;
         lastill_ff <= 1'b0;
         cyc_ff <= 8'h0;
         last_cyc_ff <= 8'h0;
         prdata_ff <= 32'h0;
         perr_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         low_ff <= nxt_low;
         sp_ff <= nxt_sp;
         lr_ff <= nxt_lr;
         pc_ff <= nxt_pc;
         flags_ff <= nxt_flags;
         en_ff <= nxt_en;
         cur_ff <= nxt_cur;
         rem_ff <= nxt_rem;
         ld_ff <= nxt_ld;
         spwb_ff <= nxt_spwb;
         sp_new_ff <= nxt_sp_new;
         refill_ff <= nxt_refill;
         mem_ff <= nxt_mem;
         done_ff <= nxt_done;
         br_ff <= nxt_br;
         ill_ff <= nxt_ill;
         lastill_ff <= nxt_lastill;
         cyc_ff <= nxt_cyc;
         last_cyc_ff <= nxt_last_cyc;
         prdata_ff <= nxt_prdata;
         perr_ff <= nxt_perr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   flags_keep_a: assert property ( // flags untouched
      !(psel && penable && pwrite) |=> $stable(flags_ff)) else $error("flags changed");
   spls_store_a: assert property ( // store address
      fire && dec.op == OP_SPLS && !dec.load |=> mem_req && mem_we &&
      mem_addr == $past(sp_ff) + {22'h0, $past(ins_word[7:0]), 2'b00})
      else $error("bad stack store");
   spls_load_a: assert property ( // load lands in register
      state_ff == ST_MEM && mem_ack && !mem_we && cur_ff < LR_SLOT
      |=> low_ff[$past(cur_ff[2:0])] == $past(mem_rdata)) else $error("load lost");
   adr_pc_a: assert property ( // pc based address
      fire && ins_word[15:11] == {PFX_ADR, 1'b0} |=> low_ff[$past(ins_word[10:8])] ==
      (($past(ins_addr) + PC_AHEAD) & PC_BIT1_CLR) + {22'h0, $past(ins_word[7:0]), 2'b00})
      else $error("bad pc address");
   sp_adj_a: assert property ( // stack adjust
      fire && ins_word[15:8] == {PFX_MISC, SUB_ADDSP} |=> sp_ff == ($past(ins_word[7]) ?
      $past(sp_ff) - {23'h0, $past(ins_word[6:0]), 2'b00} :
      $past(sp_ff) + {23'h0, $past(ins_word[6:0]), 2'b00})) else $error("bad adjust");
   push_base_a: assert property ( // push pre-decrement
      fire && dec.op == OP_PP && !dec.load && dec.mask != 9'h0 |=> mem_we &&
      mem_addr == $past(sp_ff) - (32'($countones($past(ins_word[8:0]))) << 2))
      else $error("bad push base");
   pop_base_a: assert property ( // pop from pointer
      fire && dec.op == OP_PP && dec.load && dec.mask != 9'h0 |=> !mem_we &&
      mem_addr == $past(sp_ff)) else $error("bad pop base");
   lr_store_a: assert property ( // link register stored
      mem_req && mem_we && cur_ff == LR_SLOT |-> mem_wdata == lr_ff)
      else $error("link register not stored");
   pp_decode_a: assert property ( // push/pop decode
      ins_word[15:12] == PFX_MISC && ins_word[10:9] == SUB_PP |-> dec.op == OP_PP &&
      dec.mask == ins_word[8:0] && dec.load == ins_word[11]) else $error("bad decode");
   alu_cycle_a: assert property ( // single cycle arithmetic
      fire && (dec.op == OP_ADR || dec.op == OP_ADDSP) |=> done && last_cyc_ff == CYC_ONE)
      else $error("arithmetic not single cycle");
   pop_pc_a: assert property ( // return loads pc
      state_ff == ST_MEM && mem_ack && !mem_we && cur_ff == LR_SLOT
      |=> pc_ff == $past(mem_rdata) ##[2:3] branch_valid) else $error("return lost");

   push_lr_c: cover property (fire && dec.op == OP_PP && !dec.load && dec.mask[8]);
   pop_pc_c: cover property (branch_valid && done);
   spls_load_c: cover property (fire && dec.op == OP_SPLS && dec.load);
   sp_sub_c: cover property (fire && dec.op == OP_ADDSP && dec.neg);
endmodule // csld_core

/* File: csld_mem_model.sv */
// data memory model answering the execute unit's word requests
module csld_mem_model
   import csld_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   output logic [31:0] mem_rdata,
   output logic mem_ack,
   input wire logic [1:0] wait_cyc
);
   logic [31:0] mem [0:511];
   logic [1:0] cnt_ff;
   logic [1:0] nxt_cnt;
   logic [31:0] last_ff;
   ////////////////////////////////////////////////////////////////
   // ack after wait_cyc stalled cycles, data toggles when idle
   assign mem_ack = mem_req && (cnt_ff == wait_cyc);
   assign mem_rdata = mem_ack ? mem[mem_addr[10:2]] : ~last_ff;
   always_comb
   begin
      nxt_cnt = (mem_req && !mem_ack) ? cnt_ff + 2'h1 : 2'h0;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_ff <= 2'h0;
         last_ff <= 32'h0;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
         last_ff <= mem_rdata;
      end
   end
   always @(posedge pclk)
   begin
      if (mem_ack && mem_we)
         mem[mem_addr[10:2]] <= mem_wdata;
   end
endmodule // csld_mem_model

/* File: tb.sv */
// testbench of the compressed stack load/store execute unit
module tb
   import csld_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, ins_addr, branch_target, mem_addr, mem_wdata, mem_rdata;
   logic [15:0] ins_word;
   logic ins_valid, ins_ready, done, illegal, branch_valid, mem_req, mem_we, mem_ack;
   logic [1:0] wait_cyc;
   logic [31:0] q_s, tgt_s;
   logic e_s, ill_s, br_s;
   int error_cnt = 0;
   int compares = 0;
   int k;
   logic [15:0] adj_w [4] = '{16'hb043, 16'hb09a, 16'hb07f, 16'hb0ff};
   logic [31:0] adj_sp [4] = '{32'h20c, 32'h1a4, 32'h3a0, 32'h1a4};
   csld_core dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ins_valid(ins_valid), .ins_ready(ins_ready),
      .ins_word(ins_word), .ins_addr(ins_addr), .done(done), .illegal(illegal),
      .branch_valid(branch_valid), .branch_target(branch_target), .mem_req(mem_req),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .mem_ack(mem_ack));
   csld_mem_model mem_i (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .mem_ack(mem_ack), .wait_cyc(wait_cyc));
   ////////////////////////////////////////////////////////////////
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   task automatic conclude();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
         error_cnt++;
      end
   endtask
   // bounded wait for pready, ins_ready or done
   task automatic wt(input int s);
      int n;
      n = 0;
      @(posedge pclk);
      while ((s == 0 ? pready : s == 1 ? ins_ready : done) !== 1'b1 && n < 40)
      begin
         @(posedge pclk);
         n++;
      end
      if (n >= 40)
      begin
         error_cnt++;
         conclude();
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      wt(0);
      q_s = prdata;
      e_s = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      acc(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      acc(1'b0, a, 32'h0);
      chk(q_s, exp);
   endtask
   task automatic stat(input logic [7:0] c);
      rd(OFF_STAT, {16'h0, c, 8'h0});
   endtask
   task automatic exec(input logic [15:0] w, input logic [31:0] a);
      @(posedge pclk);
      ins_valid <= 1'b1;
      ins_word <= w;
      ins_addr <= a;
      wt(1);
      ins_valid <= 1'b0;
      wt(2);
      ill_s = illegal;
      br_s = branch_valid;
      tgt_s = branch_target;
   endtask
   ////////////////////////////////////////////////////////////////
   initial
   begin
      presetn = 1'b0;
      {psel, penable, pwrite, ins_valid} = 4'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      ins_word = 16'h0;
      ins_addr = 32'h0;
      wait_cyc = 2'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(OFF_SP, SP_RST);
      rd(OFF_CTRL, 32'h1);
      rd(8'h40, 32'h0);
      chk({31'h0, e_s}, 32'h1);
      $display("test reset done");
      wr(OFF_FLAGS, 32'ha);
      wr(OFF_SP, 32'h100);
      wr(8'h10, 32'h1234abcd);
      exec(16'h947b, 32'h0);
      chk(mem_i.mem[9'hbb], 32'h1234abcd);
      stat(8'h2);
      mem_i.mem[9'h13f] = 32'h5a5a0001;
      exec(16'h9aff, 32'h0);
      rd(8'h08, 32'h5a5a0001);
      stat(8'h3);
      $display("test stack load store done");
      exec(16'ha28f, 32'h1002);
      rd(8'h08, 32'h1240);
      exec(16'hae35, 32'h0);
      rd(8'h18, 32'h1d4);
      rd(OFF_FLAGS, 32'ha);
      stat(CYC_ONE);
      $display("test address done");
      for (k = 0; k < 4; k++)
      begin
         exec(adj_w[k], 32'h0);
         rd(OFF_SP, adj_sp[k]);
      end
      rd(OFF_FLAGS, 32'ha);
      $display("test stack adjust done");
      wr(8'h00, 32'h11);
      wr(OFF_LR, 32'h3000);
      wait_cyc <= 2'h1;
      exec(16'hb511, 32'h0);
      chk(mem_i.mem[9'h66], 32'h11);
      chk(mem_i.mem[9'h67], 32'h1234abcd);
      chk(mem_i.mem[9'h68], 32'h3000);
      rd(OFF_SP, 32'h198);
      stat(8'h7);
      wait_cyc <= 2'h0;
      exec(16'hbd44, 32'h0);
      chk({31'h0, br_s}, 32'h1);
      chk(tgt_s, 32'h3000);
      chk({31'h0, ill_s}, 32'h0);
      rd(8'h08, 32'h11);
      rd(8'h18, 32'h1234abcd);
      rd(OFF_SP, 32'h1a4);
      stat(8'h7);
      wr(OFF_LR, 32'h4444);
      exec(16'hb500, 32'h0);
      chk(mem_i.mem[9'h68], 32'h4444);
      rd(OFF_SP, 32'h1a0);
      exec(16'hb100, 32'h0);
      chk({31'h0, ill_s}, 32'h1);
      rd(OFF_STAT, 32'h0000_0102);
      // enable bit off: no instruction is taken
      wr(OFF_CTRL, 32'h0);
      @(posedge pclk);
      chk({31'h0, ins_ready}, 32'h0);
      wr(OFF_CTRL, 32'h1);
      $display("test push pop done");
      conclude();
   end
endmodule // tb
